/* hdl/pipe_pkg.sv */
// Types shared by the pipeline control
package pipe_pkg;

	// Execute section selector
	typedef enum logic [1:0]
	{
		SEC_ALU,
		SEC_MULTIPLY,
		SEC_LOAD_STORE
	} section_t;

	// Execute stage sequencing
	typedef enum logic [1:0]
	{
		EXEC_IDLE,
		EXEC_RUN,
		EXEC_WAIT_MEM
	} exec_state_t;

	// Whole pipeline state
	typedef struct packed
	{
		logic                  fetch_valid;  // Fetch stage holds an insn
		logic [31:0]           fetch_insn;   // Fetched instruction
		logic                  dec_valid;    // Decode stage occupied
		logic [31:0]           dec_insn;     // Instruction in decode
		section_t              exec_section; // Section in use
		exec_state_t           exec_state;   // Execute sequencer
		logic [3:0]            exec_left;    // Cycles still needed
		logic                  retire;       // Completion pulse
		logic [31:0]           retire_insn;  // Completed instruction
	} pipe_state_t;

endpackage

/* hdl/pipe_regs.svh */
// Constants for the three-stage in-order pipeline control
`ifndef PIPE_REGS_SVH
`define PIPE_REGS_SVH

// ************************************************************
// Widths and reset values
// ************************************************************
`define PIPE_XLEN        32
`define PIPE_CNT_W       4
`define PIPE_INSN_RST    32'h0000_0000
`define PIPE_CNT_ZERO    4'h0
`define PIPE_CNT_ONE     4'h1
`define PIPE_CNT_TWO     4'h2

// ************************************************************
// Instruction word fields used for section and length decode
// ************************************************************
`define PIPE_CLS_HI      31
`define PIPE_CLS_LO      30
`define PIPE_LEN_HI      29
`define PIPE_LEN_LO      26
`define PIPE_CLS_ALU     2'h0
`define PIPE_CLS_MULTIPLY   2'h1
`define PIPE_CLS_LOAD_STORE 2'h2

`endif

/* hdl/three_stage_inorder_pipeline.sv */
// Control of a three-stage in-order pipeline: fetch, decode, execute
`timescale 1ns/1ps
`include "pipe_regs.svh"

// Behaviour
// - Exactly three stages: fetch, decode, execute in sequence.
// - Execute has ALU, multiply, load/store sections.
// - Issue and complete strictly in program order.
// - Multi-cycle op holds decode and execute stages.
// - No forwarding; stages prevent data hazards.
module three_stage_inorder_pipeline
(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// Instruction memory side
	input  wire logic                  imem_valid,
	input  wire logic [31:0]           imem_insn,
	output logic                       imem_ready,
	// Load/store data bus side
	output logic                       dbus_req,
	input  wire logic                  dbus_done,
	// Execute section strobes and completion
	output logic                       alu_busy,
	output logic                       multiply_section_busy,
	output logic                       load_store_section_busy,
	output logic                       retire_valid,
	output logic [31:0]                retire_insn
);

	// ************************************************************
	// Decode helpers
	// ************************************************************

	// Section an instruction is steered to
	function automatic pipe_pkg::section_t sec_of(input logic [31:0] w);
		logic [1:0] c;
		c = w[`PIPE_CLS_HI:`PIPE_CLS_LO];
		if (c == `PIPE_CLS_MULTIPLY)
			sec_of = pipe_pkg::SEC_MULTIPLY;
		else if (c == `PIPE_CLS_LOAD_STORE)
			sec_of = pipe_pkg::SEC_LOAD_STORE;
		else
			sec_of = pipe_pkg::SEC_ALU;
	endfunction

	// Cycle count in execute, never below one
	function automatic logic [3:0] len_of(input logic [31:0] w);
		logic [3:0] n;
		n = w[`PIPE_LEN_HI:`PIPE_LEN_LO];
		len_of = (n == `PIPE_CNT_ZERO) ? `PIPE_CNT_ONE : n;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	pipe_pkg::pipe_state_t st_reg;   // Registered state
	pipe_pkg::pipe_state_t st_next;  // Next state
	logic                  exec_done; // Execute finishes this cycle
	logic                  adv;       // Decode/execute may advance

	// Completion of the current operation
	always_comb
	begin
		case (st_reg.exec_state)
			pipe_pkg::EXEC_RUN:
				exec_done = (st_reg.exec_left == `PIPE_CNT_ONE);
			pipe_pkg::EXEC_WAIT_MEM:
				exec_done = dbus_done;
			default:
				exec_done = 1'b0;
		endcase
	end

	// Decode stage frees only once execute has nothing left to do
	assign adv = !st_reg.dec_valid || exec_done;
	// Fetch accepts only when its single slot is free or moving on
	assign imem_ready = !st_reg.fetch_valid || adv;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// One struct carries the whole pipe so every stage moves together
	always_comb
	begin
		st_next = st_reg;
		st_next.retire = 1'b0;
		// Completion from execute, oldest first
		if (st_reg.dec_valid && exec_done)
		begin
			st_next.retire = 1'b1;
			st_next.retire_insn = st_reg.dec_insn;
			st_next.dec_valid = 1'b0;
			st_next.exec_state = pipe_pkg::EXEC_IDLE;
		end
		else if (st_reg.exec_state == pipe_pkg::EXEC_RUN)
			st_next.exec_left = st_reg.exec_left - `PIPE_CNT_ONE;
		// Fetch to decode: operands are read in decode after the older
		// insn has written back, so no forwarding path is needed
		if (adv && st_reg.fetch_valid)
		begin
			st_next.dec_valid = 1'b1;
			st_next.dec_insn = st_reg.fetch_insn;
			st_next.exec_section = sec_of(st_reg.fetch_insn);
			st_next.exec_left = len_of(st_reg.fetch_insn);
			if (sec_of(st_reg.fetch_insn) == pipe_pkg::SEC_LOAD_STORE)
				st_next.exec_state = pipe_pkg::EXEC_WAIT_MEM;
			else
				st_next.exec_state = pipe_pkg::EXEC_RUN;
		end
		// Fetch slot: hold while stalled, reload when freed
		if (imem_ready)
		begin
			st_next.fetch_valid = imem_valid;
			if (imem_valid)
				st_next.fetch_insn = imem_insn;
		end
		if (rst)
		begin
			st_next.fetch_valid = 1'b0;
			st_next.fetch_insn = `PIPE_INSN_RST;
			st_next.dec_valid = 1'b0;
			st_next.dec_insn = `PIPE_INSN_RST;
			st_next.exec_section = pipe_pkg::SEC_ALU;
			st_next.exec_state = pipe_pkg::EXEC_IDLE;
			st_next.exec_left = `PIPE_CNT_ZERO;
			st_next.retire = 1'b0;
			st_next.retire_insn = `PIPE_INSN_RST;
		end
	end

	// Single state register, reset folded into next state
	always_ff @(posedge clk_sys)
	begin
		st_reg <= st_next;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Section strobes follow the registered section selector
	assign alu_busy = st_reg.dec_valid &&
		st_reg.exec_section == pipe_pkg::SEC_ALU;
	assign multiply_section_busy = st_reg.dec_valid &&
		st_reg.exec_section == pipe_pkg::SEC_MULTIPLY;
	assign load_store_section_busy = st_reg.dec_valid &&
		st_reg.exec_section == pipe_pkg::SEC_LOAD_STORE;
	assign dbus_req = st_reg.exec_state == pipe_pkg::EXEC_WAIT_MEM;
	assign retire_valid = st_reg.retire;
	assign retire_insn = st_reg.retire_insn;

	// ************************************************************
	// Assertions
	// ************************************************************
	// Fetched word moves to decode unchanged
	property p_fetch_to_dec;
		@(posedge clk_sys) disable iff (rst)
		(st_reg.fetch_valid && adv) |=>
			(st_reg.dec_valid && st_reg.dec_insn == $past(st_reg.fetch_insn));
	endproperty
	a_fetch_to_dec: assert property (p_fetch_to_dec)
		else $error("fetch word lost on way to decode");

	// Exactly one section busy while decode occupied
	property p_one_section;
		@(posedge clk_sys) disable iff (rst)
		st_reg.dec_valid |-> $onehot({alu_busy, multiply_section_busy,
			load_store_section_busy});
	endproperty
	a_one_section: assert property (p_one_section)
		else $error("not exactly one execute section busy");

	// Retired word is the one that sat in decode
	property p_retire_order;
		@(posedge clk_sys) disable iff (rst)
		retire_valid |-> retire_insn == $past(st_reg.dec_insn);
	endproperty
	a_retire_order: assert property (p_retire_order)
		else $error("completion out of program order");

	// Two-cycle op holds decode for two cycles
	property p_hold_two;
		@(posedge clk_sys) disable iff (rst)
		(st_reg.exec_state == pipe_pkg::EXEC_RUN &&
			st_reg.exec_left == `PIPE_CNT_TWO)
			|=> !retire_valid ##1 retire_valid;
	endproperty
	a_hold_two: assert property (p_hold_two)
		else $error("multi-cycle op left execute early");

	// Decode word stable while execute still busy
	property p_dec_stable;
		@(posedge clk_sys) disable iff (rst)
		(st_reg.dec_valid && !exec_done) |=> $stable(st_reg.dec_insn);
	endproperty
	a_dec_stable: assert property (p_dec_stable)
		else $error("decode overwritten while execute busy");

	// Stalled fetch keeps its word
	property p_fetch_hold;
		@(posedge clk_sys) disable iff (rst)
		(st_reg.fetch_valid && !imem_ready) |=>
			(st_reg.fetch_valid && $stable(st_reg.fetch_insn));
	endproperty
	a_fetch_hold: assert property (p_fetch_hold)
		else $error("stalled fetch lost its instruction");

	// Covers for main scenarios
	c_mul: cover property (@(posedge clk_sys) disable iff (rst)
		multiply_section_busy ##1 multiply_section_busy ##1 retire_valid);
	c_ls: cover property (@(posedge clk_sys) disable iff (rst)
		dbus_req ##1 dbus_req ##1 retire_valid);
	c_stall: cover property (@(posedge clk_sys) disable iff (rst)
		st_reg.fetch_valid && !imem_ready);
	c_b2b: cover property (@(posedge clk_sys) disable iff (rst)
		retire_valid ##1 retire_valid);

endmodule

/* verif/pipe_far_model.sv */
// Behavioural instruction memory and data bus responder
`timescale 1ns/1ps

// ************************************************************
// Far-side model
// ************************************************************
module pipe_far_model
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Instruction memory side
	output logic             imem_valid,
	output logic [31:0]      imem_insn,
	input  wire logic        imem_ready,
	// Data bus side
	input  wire logic        dbus_req,
	output logic             dbus_done
);
	logic [31:0] words[$];   // Words still to offer, oldest first
	int          mem_wait;   // Data bus wait cycles, set by the bench
	int          cnt;        // Wait cycles spent so far

	// Idle values at time zero
	initial
	begin
		imem_valid = 1'b0;
		imem_insn  = 32'h0;
		dbus_done  = 1'b0;
		mem_wait   = 0;
		cnt        = 0;
	end

	// Accepted word leaves the queue; pre-edge ready is sampled
	always @(posedge clk_sys)
	begin
		if (imem_valid && imem_ready === 1'b1)
			void'(words.pop_front());
	end

	// Offer held until taken; idle bus shows inverted garbage
	always @(negedge clk_sys)
	begin
		imem_valid <= !rst && words.size() > 0;
		imem_insn  <= (words.size() > 0) ? words[0] : ~imem_insn;
		// Single done pulse after the chosen number of waits
		dbus_done  <= dbus_req && !dbus_done && cnt == mem_wait;
		// Count restarts after each pulse so a following access
		// waits the full number of cycles again
		cnt        <= dbus_done ? 0 :
			((dbus_req && cnt < mem_wait) ? cnt + 1 :
			(dbus_req ? cnt : 0));
	end
endmodule

/* verif/test_three_stage_inorder_pipeline.sv */
// Self-checking bench for the three-stage pipeline control
`timescale 1ns/1ps

// ************************************************************
// Bench top
// ************************************************************
module test_three_stage_inorder_pipeline;
	logic        clk_sys, rst;                 // Clock, sync reset
	logic        imem_valid, imem_ready;       // Fetch handshake
	logic        dbus_req, dbus_done;          // Data bus handshake
	logic [31:0] imem_insn, retire_insn;       // Words in and out
	logic        alu_b, multiply_b, load_store_b; // Section busy
	logic        retire_valid;                 // Completion pulse
	logic [31:0] got[$];                       // Retired words
	logic [31:0] n_over;                       // Two sections busy
	int          n_mismatch, cmp_count;
	wire  [2:0]  busy = {load_store_b, multiply_b, alu_b};

	// Clock generator
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	three_stage_inorder_pipeline uut
	(
		.clk_sys(clk_sys), .rst(rst), .imem_valid(imem_valid),
		.imem_insn(imem_insn), .imem_ready(imem_ready),
		.dbus_req(dbus_req), .dbus_done(dbus_done), .alu_busy(alu_b),
		.multiply_section_busy(multiply_b),
		.load_store_section_busy(load_store_b),
		.retire_valid(retire_valid), .retire_insn(retire_insn)
	);

	pipe_far_model mdl
	(
		.clk_sys(clk_sys), .rst(rst), .imem_valid(imem_valid),
		.imem_insn(imem_insn), .imem_ready(imem_ready),
		.dbus_req(dbus_req), .dbus_done(dbus_done)
	);

	// Record completions; count cycles with two sections in use
	always @(posedge clk_sys)
	begin
		if (retire_valid === 1'b1)
			got.push_back(retire_insn);
		if (!rst && (busy & (busy - 3'h1)) != 3'h0)
			n_over <= n_over + 32'h1;
	end

	task automatic cmp(input logic [31:0] g, e, input string m);
	begin
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
		end
	end
	endtask

	task end_of_test;
	begin
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// One word alone: section used, word retired, timing from busy
	task automatic run_one(input logic [31:0] w, input int s, n);
		int         k, dk;
		bit         go;
		logic [2:0] seen;
	begin
		k = 0;
		dk = 0;
		go = 0;
		seen = 3'h0;
		got.delete();
		mdl.words.push_back(w);
		repeat (100)
		begin
			@(posedge clk_sys);
			if (go)
				k++;
			if (dbus_req === 1'b1 && dbus_done === 1'b1)
				dk = k;
			seen = seen | busy;
			go = go | (busy !== 3'h0);
			if (retire_valid === 1'b1)
				break;
		end
		// Let the recorder store the word, back on the driving edge
		@(negedge clk_sys);
		cmp(seen, 3'h1 << s, "section");
		cmp(got.size() > 0 ? got[0] : 32'h0, w, "retired word");
		// Load/store retires one cycle after the done edge
		cmp((s == 2) ? k - dk : k, (s == 2) ? 1 : n, "cycles");
	end
	endtask

	// Back-to-back mix: fetch must stall, nothing lost or reordered
	task automatic t_stream;
		logic [31:0] w[6];
		bit          stalled;
	begin
		w = '{32'h0c00_0001, 32'h5400_0002, 32'h8000_0003,
			32'hc000_0004, 32'ha400_0005, 32'h4400_0006};
		stalled = 0;
		got.delete();
		mdl.mem_wait = 2;
		foreach (w[i])
			mdl.words.push_back(w[i]);
		repeat (80)
		begin
			@(posedge clk_sys);
			stalled = stalled | (imem_valid && imem_ready === 1'b0);
		end
		cmp(stalled, 1'b1, "fetch stall");
		cmp(got.size(), 6, "count");
		foreach (w[i])
			cmp(got[i], w[i], "order");
	end
	endtask

	// Main sequence, driven on falling edges
	initial
	begin
		rst = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		n_over = 32'h0;
		repeat (5) @(negedge clk_sys);
		cmp(retire_valid, 1'b0, "reset retire");
		cmp(imem_ready, 1'b1, "reset ready");
		rst = 1'b0;
		for (int c = 0; c < 4; c++)
			run_one({c[1:0], 4'h2, 26'h10}, c == 3 ? 0 : c, 2);
		run_one(32'h4000_0020, 1, 1);
		run_one(32'h7c00_0021, 1, 15);
		mdl.mem_wait = 4;
		run_one(32'h8000_0022, 2, 0);
		t_stream;
		cmp(n_over, 32'h0, "parallel sections");
		end_of_test;
	end

	// Watchdog: the whole sequence needs well under 600 cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_mismatch++;
		end_of_test;
	end
endmodule
